/* rtl/fmf_framer.sv */
`timescale 1ns/1ps
// Function
// - Multiframe is sync (2 octets), header (4), frame stream (138).
// - Every multiframe is 144 octets, 240 ms, 4800 bit/s.
// - Octets go in order, bit 1 of each octet first.
// - Ordinary fields: lowest-numbered bit is least significant.
// - CRC fields: lowest-numbered bit holds highest polynomial term.
// - Each multiframe starts with sync word 87b2, LSB first.
// - Optional inverse sync 784d fills idle time between multiframes.
// - Header is 16 message bits in extended (31,16) cyclic codeword.
// - Header octets: rate, variant, index, spares, then check bits.
// - Rate codes 00/01/11 for 8/11/16 kHz; variant bit 0/1.
// - Nine spare header bits are sent as zeros.
// - Index starts at 0001 and counts modulo 16 per multiframe.
// - Trailing empty slots of the last multiframe are all zeros.
// - Header generator is 1 + X^8 + X^12 + X^14 + X^15.
// - Sixteenth check bit makes the 32-bit codeword even parity.
// - Each 10 ms frame is 44 index bits, not octet aligned.
// - Two frames plus 4-bit CRC 1 + X + X^4 form a pair.
// - Twelve pairs, frames 1 to 24, fill 1104 stream bits.
// - Six 6-bit indices and one 8-bit energy index per frame.
module fmf_framer
	import fmf_pkg::*;
#(
	parameter int BIT_CYCLES_P = BIT_CYCLES
)
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output      logic [31:0]           reg_rdata,
	input  wire logic                  frame_valid,
	input  wire logic [FRAME_BITS-1:0] frame_data,
	input  wire logic                  frame_last,
	output      logic                  frame_ready,
	output      logic                  ser_data,
	output      logic                  ser_valid,
	output      logic                  mf_start
);

	initial
	begin
		if (BIT_CYCLES_P < 2 || BIT_CYCLES_P > 4096)
			$error("fmf_framer: BIT_CYCLES_P out of range");
	end

	fmf_state_t            state;
	logic [3:0]            ctrl;
	logic [11:0]           bit_timer;
	logic                  tick;
	logic [4:0]            bit_idx;
	logic [6:0]            pay_pos;
	logic [3:0]            pair_cnt;
	logic [3:0]            multiframe_index;
	logic [1:0]            tx_rate;
	logic                  tx_variant;
	logic [FRAME_BITS-1:0] frame_sr;
	logic                  loaded;
	logic                  ended;
	logic                  underrun;
	logic [15:0]           mf_count;
	logic [31:0]           header_word;
	logic [3:0]            crc_val;
	logic                  emit;
	logic                  next_bit;
	logic                  in_data;
	logic                  data_shift;
	logic                  pair_done;
	logic                  mf_done;
	logic                  finish;
	logic                  take;
	logic                  start_tx;
	logic                  next_loaded;
	logic                  next_ended;
	logic                  stall;

	// Rate and variant header fields are held for a whole transmission; the index counts per multiframe.
	fmf_header_coder u_hdr (
		.sample_rate_code     (tx_rate),
		.frontend_variant_bit (tx_variant),
		.multiframe_index     (multiframe_index),
		.header_word          (header_word)
	);

	fmf_pair_crc u_crc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (pair_done),
		.shift    (data_shift),
		.din      (next_bit),
		.crc      (crc_val)
	);

	// One tick per line bit paces the stream at the multiframe rate.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			bit_timer <= 12'h000;
		else if (bit_timer == 12'(BIT_CYCLES_P - 1))
			bit_timer <= 12'h000;
		else
			bit_timer <= bit_timer + 12'h001;
	end

	assign tick = (bit_timer == 12'(BIT_CYCLES_P - 1));

	assign in_data = (state == FMF_PAY) && (pay_pos < 7'(PAIR_DATA_BITS));

	// Selects the bit due on the line in the current state.
	always_comb
	begin
		emit     = 1'b0;
		next_bit = 1'b0;
		stall    = 1'b0;
		case (state)
			FMF_FILL:
			begin
				emit     = 1'b1;
				next_bit = FILL_WORD[bit_idx[3:0]];
			end
			FMF_SYNC:
			begin
				emit     = 1'b1;
				next_bit = SYNC_WORD[bit_idx[3:0]];
			end
			FMF_HDR:
			begin
				emit     = 1'b1;
				next_bit = header_word[bit_idx];
			end
			FMF_PAY:
			begin
				if (!in_data)
				begin
					emit     = 1'b1;
					next_bit = crc_val[~pay_pos[1:0]];
				end
				else if (loaded)
				begin
					emit     = 1'b1;
					next_bit = frame_sr[0];
				end
				else if (ended)
				begin
					emit     = 1'b1;
					next_bit = 1'b0;
				end
				else
					stall    = 1'b1;
			end
			default:
			begin
				emit     = 1'b0;
				next_bit = 1'b0;
			end
		endcase
	end

	assign data_shift = tick && emit && in_data;
	assign pair_done  = (tick && state == FMF_PAY
		&& pay_pos == 7'(PAIR_BITS - 1))
		|| (state == FMF_SYNC);
	assign mf_done    = tick && state == FMF_PAY
		&& pay_pos == 7'(PAIR_BITS - 1)
		&& pair_cnt == 4'(PAIRS_PER_MF - 1);
	assign finish     = mf_done && ended && !loaded;
	assign start_tx   = loaded && !ended_active(state)
		&& ((state == FMF_IDLE)
		|| (state == FMF_FILL && tick && bit_idx == 5'(SYNC_BITS - 1)));

	function automatic logic ended_active(input fmf_state_t s);
		ended_active = (s == FMF_SYNC) || (s == FMF_HDR) || (s == FMF_PAY);
	endfunction

	// Sequence of the multiframe fields.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state    <= FMF_IDLE;
			bit_idx  <= 5'h00;
			pay_pos  <= 7'h00;
			pair_cnt <= 4'h0;
		end
		else
		begin
			case (state)
				FMF_IDLE:
				begin
					bit_idx <= 5'h00;
					if (start_tx)
						state <= FMF_SYNC;
					else if (ctrl[CTRL_FILL])
						state <= FMF_FILL;
				end
				FMF_FILL:
				begin
					if (tick)
					begin
						if (bit_idx == 5'(SYNC_BITS - 1))
						begin
							bit_idx <= 5'h00;
							if (start_tx)
								state <= FMF_SYNC;
							else if (!ctrl[CTRL_FILL])
								state <= FMF_IDLE;
						end
						else
							bit_idx <= bit_idx + 5'h01;
					end
				end
				FMF_SYNC:
				begin
					if (tick)
					begin
						if (bit_idx == 5'(SYNC_BITS - 1))
						begin
							bit_idx <= 5'h00;
							state   <= FMF_HDR;
						end
						else
							bit_idx <= bit_idx + 5'h01;
					end
				end
				FMF_HDR:
				begin
					if (tick)
					begin
						if (bit_idx == 5'(HDR_BITS - 1))
						begin
							bit_idx  <= 5'h00;
							pay_pos  <= 7'h00;
							pair_cnt <= 4'h0;
							state    <= FMF_PAY;
						end
						else
							bit_idx <= bit_idx + 5'h01;
					end
				end
				FMF_PAY:
				begin
					if (tick && emit)
					begin
						if (pay_pos == 7'(PAIR_BITS - 1))
						begin
							pay_pos  <= 7'h00;
							pair_cnt <= pair_cnt + 4'h1;
							if (mf_done && finish)
								state <= FMF_IDLE;
							else if (mf_done)
								state <= FMF_SYNC;
						end
						else
							pay_pos <= pay_pos + 7'h01;
					end
				end
				default:
					state <= FMF_IDLE;
			endcase
		end
	end

	// Multiframe index and the header fields of a transmission.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			multiframe_index <= MF_FIRST;
			tx_rate          <= RATE_8K;
			tx_variant       <= FE_STD;
			mf_count         <= 16'h0000;
		end
		else if (start_tx)
		begin
			multiframe_index <= MF_FIRST;
			tx_rate          <= ctrl[CTRL_RATE_LO +: 2];
			tx_variant       <= ctrl[CTRL_FE];
			mf_count         <= mf_count + 16'h0001;
		end
		else if (mf_done && !finish)
		begin
			multiframe_index <= multiframe_index + 4'h1;
			mf_count         <= mf_count + 16'h0001;
		end
	end

	assign take = frame_valid && frame_ready;

	always_comb
	begin
		next_loaded = loaded;
		next_ended  = ended;
		if (data_shift && loaded && (pay_pos == 7'(FRAME_BITS - 1)
			|| pay_pos == 7'(PAIR_DATA_BITS - 1)))
			next_loaded = 1'b0;
		if (take)
		begin
			next_loaded = 1'b1;
			next_ended  = frame_last;
		end
		if (finish)
			next_ended  = 1'b0;
	end

	// Single frame holding register fed by the quantizer.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			frame_sr    <= '0;
			loaded      <= 1'b0;
			ended       <= 1'b0;
			frame_ready <= 1'b0;
		end
		else
		begin
			if (take)
				frame_sr <= frame_data;
			else if (data_shift && loaded)
				frame_sr <= frame_sr >> 1;
			loaded      <= next_loaded;
			ended       <= next_ended;
			frame_ready <= !next_loaded && !next_ended;
		end
	end

	// Line outputs.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ser_data  <= 1'b0;
			ser_valid <= 1'b0;
			mf_start  <= 1'b0;
		end
		else
		begin
			ser_valid <= tick && emit;
			ser_data  <= (tick && emit) ? next_bit : 1'b0;
			mf_start  <= tick && state == FMF_SYNC && bit_idx == 5'h00;
		end
	end

	// Control register and underrun flag; a new underrun beats the clear.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			ctrl <= CTRL_RESET;
		else if (reg_wr && reg_addr == REG_CTRL)
			ctrl <= reg_wdata[3:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			underrun <= 1'b0;
		else if (tick && stall)
			underrun <= 1'b1;
		else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_UNDER])
			underrun <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			case (reg_addr)
				REG_CTRL:
					reg_rdata <= {28'h0000000, ctrl};
				REG_STATUS:
					reg_rdata <= {25'h0000000, underrun, multiframe_index,
						ended, ended_active(state)};
				REG_COUNT:
					reg_rdata <= {16'h0000, mf_count};
				default:
					reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end

endmodule

/* rtl/fmf_pkg.sv */
package fmf_pkg;

	// Multiframe layout, in octets and bits.
	localparam int SYNC_OCTETS    = 2;
	localparam int HDR_OCTETS     = 4;
	localparam int PAY_OCTETS     = 138;
	localparam int MF_OCTETS      = SYNC_OCTETS + HDR_OCTETS + PAY_OCTETS;
	localparam int SYNC_BITS      = SYNC_OCTETS * 8;
	localparam int HDR_BITS       = HDR_OCTETS * 8;
	localparam int PAY_BITS       = PAY_OCTETS * 8;

	// Frame and pair layout.
	localparam int SIX_IDX_COUNT  = 6;
	localparam int SIX_IDX_BITS   = 6;
	localparam int ENERGY_BITS    = 8;
	localparam int FRAME_BITS     = SIX_IDX_COUNT * SIX_IDX_BITS + ENERGY_BITS;
	localparam int PAIR_DATA_BITS = 2 * FRAME_BITS;
	localparam int PAIR_CRC_BITS  = 4;
	localparam int PAIR_BITS      = PAIR_DATA_BITS + PAIR_CRC_BITS;
	localparam int PAIRS_PER_MF   = 12;

	// Fixed words, sent least significant bit first.
	localparam logic [15:0] SYNC_WORD = 16'h87b2;
	localparam logic [15:0] FILL_WORD = 16'h784d;

	// Header code: generator terms below X^15 and pair CRC terms below X^4.
	localparam logic [14:0] HDR_GEN_LOW = 15'h5101;
	localparam logic [3:0]  CRC_GEN_LOW = 4'h3;
	localparam int          SPARE_BITS  = 9;
	localparam logic [8:0]  SPARE_VALUE = 9'h000;
	localparam logic [3:0]  MF_FIRST    = 4'h1;

	// Sample-rate codes and front-end variants.
	localparam logic [1:0] RATE_8K   = 2'h0;
	localparam logic [1:0] RATE_11K  = 2'h1;
	localparam logic [1:0] RATE_16K  = 2'h3;
	localparam logic       FE_STD    = 1'b0;
	localparam logic       FE_ROBUST = 1'b1;

	// Timing.
	localparam int CLK_HZ      = 10_000_000;
	localparam int MF_TIME_MS  = 240;
	localparam int BIT_RATE    = MF_OCTETS * 8 * 1000 / MF_TIME_MS;
	localparam int BIT_CYCLES  = CLK_HZ / BIT_RATE;

	// Register map, word indices on the plain register port.
	localparam int          REG_ADDR_W  = 4;
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_STATUS  = 4'h1;
	localparam logic [3:0]  REG_COUNT   = 4'h2;
	localparam int          CTRL_RATE_LO = 0;
	localparam int          CTRL_FE      = 2;
	localparam int          CTRL_FILL    = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h0;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_ENDED   = 1;
	localparam int          STAT_IDX_LO  = 2;
	localparam int          STAT_UNDER   = 6;

	typedef enum logic [2:0] {
		FMF_IDLE,
		FMF_FILL,
		FMF_SYNC,
		FMF_HDR,
		FMF_PAY
	} fmf_state_t;

endpackage

/* rtl/fmf_header_coder.sv */
`timescale 1ns/1ps
module fmf_header_coder
	import fmf_pkg::*;
(
	input  wire logic [1:0]  sample_rate_code,
	input  wire logic        frontend_variant_bit,
	input  wire logic [3:0]  multiframe_index,
	output      logic [31:0] header_word
);

	logic [15:0] message;
	logic [14:0] remainder;
	logic        overall;

	// Message bit i is the coefficient of X^i; division by the generator
	// runs from the highest message term down.
	always_comb
	begin
		logic fb;
		fb        = 1'b0;
		message   = {SPARE_VALUE, multiframe_index, frontend_variant_bit,
			sample_rate_code};
		remainder = 15'h0000;
		for (int i = 15; i >= 0; i--)
		begin
			fb        = message[i] ^ remainder[14];
			remainder = {remainder[13:0], 1'b0} ^ (fb ? HDR_GEN_LOW : 15'h0000);
		end
		overall     = ^{message, remainder};
		header_word = {overall, remainder, message};
	end

endmodule

/* rtl/fmf_pair_crc.sv */
`timescale 1ns/1ps
module fmf_pair_crc
	import fmf_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       shift,
	input  wire logic       din,
	output      logic [3:0] crc
);

	logic fb;

	assign fb = din ^ crc[3];

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || clear)
			crc <= 4'h0;
		else if (shift)
			crc <= {crc[2:0], 1'b0} ^ (fb ? CRC_GEN_LOW : 4'h0);
	end

endmodule

/* dv/fmf_framer_sva.sv */
`timescale 1ns/1ps
module fmf_framer_sva
	import fmf_pkg::*;
#(
	parameter int BIT_CYCLES_P = 4
)
(
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  reg_rd,
	input wire logic [31:0]           reg_rdata,
	input wire logic                  frame_valid,
	input wire logic                  frame_ready,
	input wire logic                  ser_data,
	input wire logic                  ser_valid,
	input wire logic                  mf_start
);
	int   gap;
	logic seen;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || ser_valid)
			gap <= 0;
		else
			gap <= gap + 1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			seen <= 1'b0;
		else if (ser_valid)
			seen <= 1'b1;
	end

	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Second and third sync bits follow on the next two line ticks.
	sequence sync_lead;
		##BIT_CYCLES_P (ser_valid && ser_data)
		##BIT_CYCLES_P (ser_valid && !ser_data);
	endsequence

	AST_PULSE: assert property (ser_valid |=> !ser_valid)
		else $error("line strobe longer than one cycle");
	AST_RATE: assert property (ser_valid |-> !seen || gap >= BIT_CYCLES_P-1)
		else $error("line bits closer than one bit time");
	AST_IDLE_ZERO: assert property (!ser_valid |-> !ser_data)
		else $error("line data high outside a bit");
	AST_START_BIT: assert property (mf_start |-> ser_valid && !ser_data)
		else $error("multiframe start without sync bit zero");
	AST_SYNC_LEAD: assert property (mf_start |-> sync_lead)
		else $error("sync word bits out of order");
	AST_MF_ALONE: assert property (mf_start |=> !mf_start [*8])
		else $error("multiframe start repeated");
	AST_TAKE: assert property (frame_valid && frame_ready |=> !frame_ready)
		else $error("ready held after a frame was taken");
	AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside the answer cycle");
endmodule

bind fmf_framer fmf_framer_sva #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_sva (
	.core_clk    (core_clk),
	.rst_n       (rst_n),
	.reg_rd      (reg_rd),
	.reg_rdata   (reg_rdata),
	.frame_valid (frame_valid),
	.frame_ready (frame_ready),
	.ser_data    (ser_data),
	.ser_valid   (ser_valid),
	.mf_start    (mf_start)
);

/* dv/fmf_line_rx.sv */
`timescale 1ns/1ps
module fmf_line_rx
#(
	parameter int MAX_BITS = 4096
)
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ser_valid,
	input  wire logic        ser_data,
	output      logic [15:0] bit_count
);
	logic line_bits [MAX_BITS];

	// The channel keeps the first MAX_BITS strobed bits in arrival order.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			bit_count <= 16'h0000;
		else if (ser_valid)
		begin
			line_bits[bit_count] <= ser_data;
			bit_count <= bit_count + 16'h0001;
		end
	end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import fmf_pkg::*;
();
	localparam int NFR = 27;
	logic                  core_clk    = 1'b0;
	logic                  rst_n       = 1'b0;
	logic [3:0]            reg_addr    = 4'h0;
	logic [31:0]           reg_wdata   = 32'h0;
	logic                  reg_wr      = 1'b0;
	logic                  reg_rd      = 1'b0;
	logic                  frame_valid = 1'b0;
	logic                  frame_last  = 1'b0;
	logic [FRAME_BITS-1:0] frame_data  = '0;
	logic [31:0]           reg_rdata;
	logic                  frame_ready;
	logic                  ser_data;
	logic                  ser_valid;
	logic                  mf_start;
	logic [15:0]           bit_count;
	int                    bad_count   = 0;
	int                    check_count = 0;
	int                    cyc         = 0;
	logic                  exp_bits [$];

	fmf_framer #(.BIT_CYCLES_P(4)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_valid(frame_valid),
		.frame_data(frame_data), .frame_last(frame_last),
		.frame_ready(frame_ready), .ser_data(ser_data),
		.ser_valid(ser_valid), .mf_start(mf_start)
	);

	fmf_line_rx rx (
		.core_clk(core_clk), .rst_n(rst_n), .ser_valid(ser_valid),
		.ser_data(ser_data), .bit_count(bit_count)
	);

	always #50 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	function automatic logic [FRAME_BITS-1:0] fval(input int k);
		logic [7:0] b;
		b = k[7:0];
		return {b ^ 8'h5a, {3{b, 4'h9}}};
	endfunction

	task automatic push_bits(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			exp_bits.push_back(v[i]);
	endtask

	// Expected line bits of one multiframe sent at 16 kHz, robust variant.
	task automatic build_mf(input logic [3:0] idx, input int first);
		logic [15:0]           msg;
		logic [14:0]           r;
		logic [3:0]            c;
		logic [FRAME_BITS-1:0] f;
		logic                  fb;
		msg = {9'h000, idx, 1'b1, 2'h3};
		r = 15'h0000;
		for (int i = 15; i >= 0; i--)
		begin
			fb = msg[i] ^ r[14];
			r = {r[13:0], 1'b0} ^ (fb ? 15'h5101 : 15'h0000);
		end
		push_bits(32'h0000_87b2, 16);
		push_bits({^{r, msg}, r, msg}, 32);
		for (int p = 0; p < 12; p++)
		begin
			c = 4'h0;
			for (int j = 0; j < 2; j++)
			begin
				f = (first + 2*p + j <= NFR) ? fval(first + 2*p + j) : '0;
				for (int i = 0; i < FRAME_BITS; i++)
				begin
					exp_bits.push_back(f[i]);
					fb = f[i] ^ c[3];
					c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
				end
			end
			push_bits({28'h0, c[0], c[1], c[2], c[3]}, 4);
		end
	endtask

	task automatic feed();
		for (int k = 1; k <= NFR; k++)
		begin
			frame_valid <= 1'b1;
			frame_data <= fval(k);
			frame_last <= (k == NFR);
			// Wait for the edge that samples ready high, before it updates.
			@(posedge core_clk iff frame_ready === 1'b1);
		end
		frame_valid <= 1'b0;
		frame_last <= 1'b0;
	endtask

	initial
	begin
		logic [31:0] d;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		reg_read(REG_CTRL, d);
		chk(d, 32'h0);
		reg_read(REG_STATUS, d);
		chk({28'h0, d[5:2]}, 32'h1);
		reg_read(4'hf, d);
		chk(d, 32'h0);
		reg_write(REG_CTRL, 32'h0000_0007);
		reg_read(REG_CTRL, d);
		chk(d, 32'h7);
		build_mf(4'h1, 1);
		build_mf(4'h2, 25);
		feed();
		for (int i = 0; i < 6000 && bit_count < 16'd2304; i++)
			@(posedge core_clk);
		repeat (40) @(posedge core_clk);
		chk({16'h0, bit_count}, exp_bits.size());
		for (int i = 0; i < 2304; i++)
			chk({31'h0, rx.line_bits[i]}, {31'h0, exp_bits[i]});
		reg_read(REG_STATUS, d);
		chk(d, 32'h0000_0008);
		reg_write(REG_CTRL, 32'h0000_000f);
		push_bits(32'h0000_784d, 16);
		for (int i = 0; i < 400 && bit_count < 16'd2320; i++)
			@(posedge core_clk);
		for (int i = 2304; i < 2320; i++)
			chk({31'h0, rx.line_bits[i]}, {31'h0, exp_bits[i]});
		reg_read(REG_COUNT, d);
		chk(d, 32'h2);
		close_out();
	end
endmodule
